// *** rtl/cmd_cfg.sv ***
// Command-behaviour configuration: boot (one-time) and live copies, reached over the serial link.
// Assumes SPI mode 0 with the serial clock well below a quarter of the core clock.
`timescale 1ns/1ps
// What this block does
// - Both copies readable and writable by link commands
// - Every reset reloads live copy from boot
// - Boot bits start at zero, set once
// - Blank check tests status, erases failed sectors
// - Successful sector: erase on zero, else skip
// - Blank check on parameter, sector, bulk erase
// - Page buffer wraps at 512 or 256
// - Hybrid map allows 4 kB erase; uniform not
// - Instruction 30h is resume or clear status
// - D8h and DCh erase 64 or 256 kB
// - Legacy F0h reset only when allowed
// - Reset enable then reset always resets
// - Reserved bits zero and without effect
// - Address length follows four-byte mode input
module cmd_cfg (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Serial link pins and hardware reset pin
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic hw_reset_n_i,
  output logic so_o,
  output logic so_oe_o,
  // Same-domain configuration input
  input wire logic addr_4byte_i,
  // Configuration outputs to the command engines
  output cmd_cfg_pkg::cfg_t cfg_live_o,
  output logic [8:0] page_last_o,
  // Decoded command pulses; erase kind and blank check hold their values from the last erase
  output logic resume_o,
  output logic clear_status_o,
  output logic soft_reset_o,
  output logic erase_go_o,
  output cmd_cfg_pkg::erase_kind_t erase_kind_o,
  output logic erase_blank_check_o
);
  typedef enum logic [1:0] {ST_CMD, ST_ADDR, ST_DATA, ST_IGNORE} link_st_t;
  typedef enum logic [2:0] {PEND_NONE, PEND_RESUME, PEND_CLEAR, PEND_RESET, PEND_ERASE, PEND_WRITE} pend_t;

  logic sck_s, cs_n_s, si_s, hw_n_s;
  logic sck_d_r, cs_n_d_r;
  link_st_t st_r;
  pend_t pend_r;
  logic [2:0] bit_r;
  logic [2:0] abytes_r;
  logic [6:0] shift_r;
  logic [31:0] addr_r;
  logic is_write_r;
  logic reset_armed_r;
  logic [7:0] wdata_r;
  logic [7:0] out_r;
  cmd_cfg_pkg::erase_kind_t pend_kind_r;
  cmd_cfg_pkg::cfg_t boot_r;
  localparam int BIT_IDX = cmd_cfg_pkg::BIT_UNIFORM;
  logic sck_rise, sck_fall, cs_rise, byte_done;
  logic [7:0] byte_in;

  // Reset to the idle pin levels (clock low, chip select high, reset pin high) so no false edge follows reset.
  pin_sync #(.WIDTH(4), .INIT(4'h5)) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .async_i({sck_i, cs_n_i, si_i, hw_reset_n_i}),
    .sync_o({sck_s, cs_n_s, si_s, hw_n_s})
  );

  // Last page-buffer offset before wrapping to zero.
  function automatic logic [8:0] wrap_last(input cmd_cfg_pkg::cfg_t c);
    wrap_last = c.page_buffer_wrap ? cmd_cfg_pkg::PAGE_LAST_512 : cmd_cfg_pkg::PAGE_LAST_256;
  endfunction

  // Compares a link address with a register address; in three-byte mode only the low 24 bits are compared.
  function automatic logic match(input logic [31:0] a, input logic [31:0] reg_addr, input logic four);
    match = four ? (a == reg_addr) : (a[23:0] == reg_addr[23:0]);
  endfunction

  assign sck_rise = sck_s && !sck_d_r;
  assign sck_fall = !sck_s && sck_d_r;
  assign cs_rise = cs_n_s && !cs_n_d_r;
  assign byte_done = sck_rise && !cs_n_s && (bit_r == 3'h7);
  assign byte_in = {shift_r, si_s};

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sck_d_r <= 1'b0;
      cs_n_d_r <= 1'b1;
    end else begin
      sck_d_r <= sck_s;
      cs_n_d_r <= cs_n_s;
    end
  end

  // Serial receive and command framing.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || cs_n_s || soft_reset_o) begin
      st_r <= ST_CMD;
      bit_r <= 3'h0;
      shift_r <= 7'h00;
      abytes_r <= 3'h0;
      addr_r <= 32'h0000_0000;
      is_write_r <= 1'b0;
    end else if (sck_rise) begin
      shift_r <= byte_in[6:0];
      bit_r <= bit_r + 3'h1;
      if (byte_done) begin
        case (st_r)
          ST_CMD: begin
            if (byte_in == cmd_cfg_pkg::OP_READ_ANY_REG || byte_in == cmd_cfg_pkg::OP_WRITE_ANY_REG) begin
              st_r <= ST_ADDR;
              is_write_r <= (byte_in == cmd_cfg_pkg::OP_WRITE_ANY_REG);
              abytes_r <= addr_4byte_i ? cmd_cfg_pkg::ADDR_BYTES_4 : cmd_cfg_pkg::ADDR_BYTES_3;
            end else begin
              st_r <= ST_IGNORE;
            end
          end
          ST_ADDR: begin
            addr_r <= {addr_r[23:0], byte_in};
            abytes_r <= abytes_r - 3'h1;
            if (abytes_r == 3'h1) begin
              st_r <= ST_DATA;
            end
          end
          ST_DATA: begin
            st_r <= ST_IGNORE;
          end
          ST_IGNORE: begin
            st_r <= ST_IGNORE;
          end
          default: begin
            st_r <= ST_IGNORE;
          end
        endcase
      end
    end
  end

  // Pending action, decided on the instruction byte (or on the data byte of a write) and carried out at chip-select rise.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || soft_reset_o) begin
      pend_r <= PEND_NONE;
      pend_kind_r <= cmd_cfg_pkg::ERASE_SECTOR_64K;
      wdata_r <= 8'h00;
    end else if (cs_rise) begin
      pend_r <= PEND_NONE;
    end else if (byte_done && st_r == ST_CMD) begin
      pend_r <= PEND_NONE;
      case (byte_in)
        cmd_cfg_pkg::OP_CODE_30: begin
          pend_r <= cfg_live_o.resume_code_select ? PEND_RESUME : PEND_CLEAR;
        end
        cmd_cfg_pkg::OP_LEGACY_RESET: begin
          pend_r <= cfg_live_o.legacy_reset_allow ? PEND_RESET : PEND_NONE;
        end
        cmd_cfg_pkg::OP_RESET: begin
          pend_r <= reset_armed_r ? PEND_RESET : PEND_NONE;
        end
        cmd_cfg_pkg::OP_ERASE_4K: begin
          pend_r <= cfg_live_o.uniform_sector ? PEND_NONE : PEND_ERASE;
          pend_kind_r <= cmd_cfg_pkg::ERASE_PARAM_4K;
        end
        cmd_cfg_pkg::OP_ERASE_BLK3, cmd_cfg_pkg::OP_ERASE_BLK4: begin
          pend_r <= PEND_ERASE;
          pend_kind_r <= cfg_live_o.block_erase_size ? cmd_cfg_pkg::ERASE_BLOCK_256K
                                                     : cmd_cfg_pkg::ERASE_SECTOR_64K;
        end
        cmd_cfg_pkg::OP_ERASE_BULK_A, cmd_cfg_pkg::OP_ERASE_BULK_B: begin
          pend_r <= PEND_ERASE;
          pend_kind_r <= cmd_cfg_pkg::ERASE_BULK;
        end
        default: begin
          pend_r <= PEND_NONE;
        end
      endcase
    end else if (byte_done && st_r == ST_DATA && is_write_r) begin
      pend_r <= PEND_WRITE;
      wdata_r <= byte_in;
    end
  end

  // The reset-enable instruction arms only the command that follows it.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || soft_reset_o) begin
      reset_armed_r <= 1'b0;
    end else if (byte_done && st_r == ST_CMD) begin
      reset_armed_r <= (byte_in == cmd_cfg_pkg::OP_RESET_ENABLE);
    end
  end

  // Read data for the register read command, shifted out on falling edges.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || cs_n_s) begin
      out_r <= 8'h00;
      so_o <= 1'b0;
      so_oe_o <= 1'b0;
    end else if (byte_done && st_r == ST_ADDR && abytes_r == 3'h1 && !is_write_r) begin
      if (match({addr_r[23:0], byte_in}, cmd_cfg_pkg::ADDR_CFG_BOOT, addr_4byte_i)) begin
        out_r <= boot_r;
      end else if (match({addr_r[23:0], byte_in}, cmd_cfg_pkg::ADDR_CFG_LIVE, addr_4byte_i)) begin
        out_r <= cfg_live_o;
      end else begin
        out_r <= 8'h00;
      end
    end else if (sck_fall && st_r == ST_DATA && !is_write_r) begin
      so_o <= out_r[7];
      so_oe_o <= 1'b1;
      out_r <= {out_r[6:0], out_r[7]};
    end
  end

  // Boot copy: factory zero, each bit may only be set once.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      boot_r <= cmd_cfg_pkg::CFG_FACTORY;
    end else if (cs_rise && pend_r == PEND_WRITE && match(addr_r, cmd_cfg_pkg::ADDR_CFG_BOOT, addr_4byte_i)) begin
      boot_r <= boot_r | (wdata_r & cmd_cfg_pkg::MASK_BOOT_WR);
    end
  end

  // Live copy: reloaded on every reset, written at chip-select rise.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cfg_live_o <= cmd_cfg_pkg::CFG_FACTORY;
    end else if (!hw_n_s || soft_reset_o) begin
      cfg_live_o <= boot_r;
    end else if (cs_rise && pend_r == PEND_WRITE && match(addr_r, cmd_cfg_pkg::ADDR_CFG_LIVE, addr_4byte_i)) begin
      cfg_live_o <= (wdata_r & cmd_cfg_pkg::MASK_LIVE_WR) | (boot_r & ~cmd_cfg_pkg::MASK_LIVE_WR & 8'h08);
    end else if (cs_rise && pend_r == PEND_WRITE && match(addr_r, cmd_cfg_pkg::ADDR_CFG_BOOT, addr_4byte_i)) begin
      cfg_live_o[BIT_IDX] <= boot_r[BIT_IDX] | wdata_r[BIT_IDX];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      page_last_o <= cmd_cfg_pkg::PAGE_LAST_256;
    end else begin
      page_last_o <= wrap_last(cfg_live_o);
    end
  end

  // Command pulses issued when chip select rises.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      resume_o <= 1'b0;
      clear_status_o <= 1'b0;
      soft_reset_o <= 1'b0;
      erase_go_o <= 1'b0;
      erase_kind_o <= cmd_cfg_pkg::ERASE_SECTOR_64K;
      erase_blank_check_o <= 1'b0;
    end else begin
      resume_o <= cs_rise && pend_r == PEND_RESUME;
      clear_status_o <= cs_rise && pend_r == PEND_CLEAR;
      soft_reset_o <= cs_rise && pend_r == PEND_RESET;
      erase_go_o <= cs_rise && pend_r == PEND_ERASE;
      if (cs_rise && pend_r == PEND_ERASE) begin
        erase_kind_o <= pend_kind_r;
        erase_blank_check_o <= cfg_live_o.erase_skip_check;
      end
    end
  end

  // Checks.
  live_reload_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    soft_reset_o |=> cfg_live_o == $past(boot_r)) else $error("live copy not reloaded on reset");
  boot_once_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ($past(boot_r) & ~boot_r) == 8'h00) else $error("boot bit returned to zero");
  reserved_zero_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cfg_live_o.reserved == 2'b00 && boot_r.reserved == 2'b00) else $error("reserved bit set");
  wrap_point_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ##1 page_last_o == ($past(cfg_live_o.page_buffer_wrap) ? 9'h1FF : 9'h0FF)) else $error("wrong wrap point");
  uniform_track_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cfg_live_o.uniform_sector |-> boot_r.uniform_sector) else $error("live sector bit differs");
  no_4k_uniform_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    erase_go_o && erase_kind_o == cmd_cfg_pkg::ERASE_PARAM_4K |-> !$past(cfg_live_o.uniform_sector, 2))
    else $error("4 kB erase in uniform map");
  code30_split_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (resume_o || clear_status_o) |-> !(resume_o && clear_status_o)
      && resume_o == $past(cfg_live_o.resume_code_select, 2))
    else $error("30h decoded against the select bit");
  live_quiet_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !cs_n_s && !cs_n_d_r && hw_n_s && !soft_reset_o |=> $stable(cfg_live_o))
    else $error("live copy changed with chip select low");
endmodule // cmd_cfg

// *** shared/cmd_cfg_pkg.sv ***
// Constants and types for the command-behaviour configuration block.
// Assumes a single 10 MHz core clock and a slow SPI mode 0 serial link.
package cmd_cfg_pkg;

  // Live or boot copy of the configuration byte.
  typedef struct packed {
    logic [1:0] reserved;
    logic erase_skip_check;
    logic page_buffer_wrap;
    logic uniform_sector;
    logic resume_code_select;
    logic block_erase_size;
    logic legacy_reset_allow;
  } cfg_t;

  typedef enum logic [1:0] {
    ERASE_PARAM_4K,
    ERASE_SECTOR_64K,
    ERASE_BLOCK_256K,
    ERASE_BULK
  } erase_kind_t;

  // Instruction codes.
  localparam logic [7:0] OP_READ_ANY_REG = 8'h65;
  localparam logic [7:0] OP_WRITE_ANY_REG = 8'h71;
  localparam logic [7:0] OP_CODE_30 = 8'h30;
  localparam logic [7:0] OP_LEGACY_RESET = 8'hF0;
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  localparam logic [7:0] OP_ERASE_4K = 8'h20;
  localparam logic [7:0] OP_ERASE_BLK3 = 8'hD8;
  localparam logic [7:0] OP_ERASE_BLK4 = 8'hDC;
  localparam logic [7:0] OP_ERASE_BULK_A = 8'h60;
  localparam logic [7:0] OP_ERASE_BULK_B = 8'hC7;

  // Register addresses on the serial link.
  localparam logic [31:0] ADDR_CFG_BOOT = 32'h0000_0004;
  localparam logic [31:0] ADDR_CFG_LIVE = 32'h0080_0004;

  // Field positions and write masks.
  localparam int BIT_UNIFORM = 3;
  localparam logic [7:0] MASK_BOOT_WR = 8'h3F;
  localparam logic [7:0] MASK_LIVE_WR = 8'h37;
  localparam logic [7:0] CFG_FACTORY = 8'h00;

  // Page buffer last offsets.
  localparam logic [8:0] PAGE_LAST_256 = 9'h0FF;
  localparam logic [8:0] PAGE_LAST_512 = 9'h1FF;

  // Address bytes.
  localparam logic [2:0] ADDR_BYTES_3 = 3'h3;
  localparam logic [2:0] ADDR_BYTES_4 = 3'h4;

endpackage

// *** rtl/pin_sync.sv ***
// Two-flop synchroniser for pin inputs.
// Assumes the pins are quasi-static relative to the core clock.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Data
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_r;

  // Refuse a width that leaves nothing to synchronise.
  if (WIDTH < 1) begin : g_width_check
    $error("pin_sync needs WIDTH of at least 1");
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      meta_r <= INIT;
      sync_o <= INIT;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule // pin_sync

// *** dv/spi_host.sv ***
// Host serial controller model: SPI mode 0 frames made of whole bytes, MSB first.
// Assumes the core clock paces it; the serial clock stays low for six core cycles and high for five.
`timescale 1ns/1ps
module spi_host (
  // Clock
  input wire logic ref_clk_i,
  // Serial link
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o,
  input wire logic so_i
);
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end

  task automatic pause(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  // Sends op, nab address bytes and nd data bytes; rd keeps the last byte seen on so.
  task automatic xfer(input logic [7:0] op, input int nab, input logic [31:0] adr,
                      input logic [7:0] wd, input int nd, output logic [7:0] rd);
    logic [7:0] b;
    int k;
    @(posedge ref_clk_i) cs_n_o <= 1'b0;
    for (k = 0; k < 1 + nab + nd; k++) begin
      b = (k == 0) ? op : (k <= nab) ? adr[8*(nab-k) +: 8] : wd;
      for (int i = 7; i >= 0; i--) begin
        @(posedge ref_clk_i) si_o <= b[i];
        pause(4);
        @(posedge ref_clk_i) sck_o <= 1'b1;
        pause(4);
        rd[i] = so_i;
        @(posedge ref_clk_i) sck_o <= 1'b0;
      end
    end
    pause(4);
    @(posedge ref_clk_i) cs_n_o <= 1'b1;
    // The idle data line never repeats the last bit sent.
    si_o <= ~si_o;
    pause(12);
  endtask
endmodule // spi_host

// *** dv/cmd_cfg_tb.sv ***
// Self-checking bench for the command-behaviour configuration block.
// Assumes the host model spi_host drives the serial link.
`timescale 1ns/1ps
module cmd_cfg_tb;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hw_reset_n_i = 1'b1;
  logic addr_4byte_i = 1'b0;
  logic sck, cs_n, si, so_o, so_oe_o;
  cmd_cfg_pkg::cfg_t cfg_live_o;
  logic [8:0] page_last_o;
  logic resume_o, clear_status_o, soft_reset_o, erase_go_o, erase_blank_check_o;
  cmd_cfg_pkg::erase_kind_t erase_kind_o;
  int bad_count = 0;
  int cmp_count = 0;
  int n_res = 0, n_clr = 0, n_rst = 0, n_ers = 0;
  int nab = 3;
  logic [7:0] rd;

  always #50 ref_clk_i = ~ref_clk_i;

  always @(posedge ref_clk_i) begin
    n_res += (resume_o === 1'b1);
    n_clr += (clear_status_o === 1'b1);
    n_rst += (soft_reset_o === 1'b1);
    n_ers += (erase_go_o === 1'b1);
  end

  cmd_cfg u_cmd_cfg (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
    .hw_reset_n_i(hw_reset_n_i), .so_o(so_o), .so_oe_o(so_oe_o), .addr_4byte_i(addr_4byte_i),
    .cfg_live_o(cfg_live_o), .page_last_o(page_last_o), .resume_o(resume_o),
    .clear_status_o(clear_status_o), .soft_reset_o(soft_reset_o), .erase_go_o(erase_go_o),
    .erase_kind_o(erase_kind_o), .erase_blank_check_o(erase_blank_check_o));
  spi_host u_spi_host (.ref_clk_i(ref_clk_i), .sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so_o));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkc(input int r, input int c, input int s, input int e);
    chk("pulses", 16'(r * 4096 + c * 256 + s * 16 + e), 16'(n_res * 4096 + n_clr * 256 + n_rst * 16 + n_ers));
  endtask
  task automatic cfg(input logic [7:0] e);
    chk("cfg", {8'h00, e}, {8'h00, cfg_live_o});
  endtask
  task automatic ers(input logic [1:0] k, input logic bc);
    chk("erase", {13'h0000, k, bc}, {13'h0000, erase_kind_o, erase_blank_check_o});
  endtask
  task automatic cmd(input logic [7:0] op, input int na);
    u_spi_host.xfer(op, na, 32'h0000_0000, 8'h00, 0, rd);
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    u_spi_host.xfer(cmd_cfg_pkg::OP_WRITE_ANY_REG, nab, a, d, 1, rd);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [7:0] e);
    u_spi_host.xfer(cmd_cfg_pkg::OP_READ_ANY_REG, nab, a, 8'h00, 1, rd);
    chk("read", {8'h00, e}, {8'h00, rd});
  endtask
  task automatic endt(input string t);
    $display("test %s done, mismatches so far %0d", t, bad_count);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #6_000_000;
    bad_count++;
    $display("MISMATCH watchdog expected done seen timeout");
    tally_and_finish();
  end

  initial begin
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (5) @(posedge ref_clk_i);
    cfg(8'h00);
    chk("page", 16'h00FF, {7'h00, page_last_o});
    ers(2'h1, 1'b0);
    rdc(cmd_cfg_pkg::ADDR_CFG_BOOT, 8'h00);
    rdc(cmd_cfg_pkg::ADDR_CFG_LIVE, 8'h00);
    rdc(32'h0000_0002, 8'h00);
    endt("reset");
    wr(cmd_cfg_pkg::ADDR_CFG_LIVE, 8'hF7);
    cfg(8'h37);
    chk("page", 16'h01FF, {7'h00, page_last_o});
    chk("so_oe", 16'h0000, {15'h0000, so_oe_o});
    rdc(cmd_cfg_pkg::ADDR_CFG_LIVE, 8'h37);
    cmd(cmd_cfg_pkg::OP_CODE_30, 0);
    chkc(1, 0, 0, 0);
    cmd(cmd_cfg_pkg::OP_ERASE_BLK3, 3);
    ers(2'h2, 1'b1);
    cmd(cmd_cfg_pkg::OP_ERASE_BULK_A, 0);
    ers(2'h3, 1'b1);
    cmd(cmd_cfg_pkg::OP_ERASE_4K, 3);
    ers(2'h0, 1'b1);
    chkc(1, 0, 0, 3);
    endt("options set");
    wr(cmd_cfg_pkg::ADDR_CFG_LIVE, 8'h00);
    chk("page", 16'h00FF, {7'h00, page_last_o});
    cmd(cmd_cfg_pkg::OP_CODE_30, 0);
    cmd(cmd_cfg_pkg::OP_ERASE_BLK4, 4);
    ers(2'h1, 1'b0);
    cmd(cmd_cfg_pkg::OP_ERASE_BULK_B, 0);
    ers(2'h3, 1'b0);
    chkc(1, 1, 0, 5);
    cmd(cmd_cfg_pkg::OP_LEGACY_RESET, 0);
    chkc(1, 1, 0, 5);
    wr(cmd_cfg_pkg::ADDR_CFG_LIVE, 8'h01);
    cmd(cmd_cfg_pkg::OP_LEGACY_RESET, 0);
    chkc(1, 1, 1, 5);
    cfg(8'h00);
    cmd(cmd_cfg_pkg::OP_RESET, 0);
    chkc(1, 1, 1, 5);
    cmd(cmd_cfg_pkg::OP_RESET_ENABLE, 0);
    cmd(cmd_cfg_pkg::OP_RESET, 0);
    chkc(1, 1, 2, 5);
    endt("resets");
    wr(cmd_cfg_pkg::ADDR_CFG_BOOT, 8'h08);
    cfg(8'h08);
    cmd(cmd_cfg_pkg::OP_ERASE_4K, 3);
    chkc(1, 1, 2, 5);
    wr(cmd_cfg_pkg::ADDR_CFG_BOOT, 8'h00);
    rdc(cmd_cfg_pkg::ADDR_CFG_BOOT, 8'h08);
    wr(cmd_cfg_pkg::ADDR_CFG_BOOT, 8'hE2);
    cfg(8'h08);
    @(posedge ref_clk_i) hw_reset_n_i <= 1'b0;
    repeat (10) @(posedge ref_clk_i);
    hw_reset_n_i <= 1'b1;
    repeat (10) @(posedge ref_clk_i);
    cfg(8'h2A);
    rdc(cmd_cfg_pkg::ADDR_CFG_BOOT, 8'h2A);
    addr_4byte_i <= 1'b1;
    nab = 4;
    wr(cmd_cfg_pkg::ADDR_CFG_LIVE, 8'h0C);
    cfg(8'h0C);
    rdc(cmd_cfg_pkg::ADDR_CFG_LIVE, 8'h0C);
    endt("boot copy");
    tally_and_finish();
  end
endmodule // cmd_cfg_tb
